/* rtl/isr_pkg.sv */
// Shared constants and types of the instrument status reporting block.
package isr_pkg;

	// ------------------------------------------------------------------
	// Widths and queue geometry
	// ------------------------------------------------------------------
	localparam int DATA_W   = 16;
	localparam int QDEPTH   = 10;
	localparam int QADDR_W  = 4;
	localparam int SLOT_W   = 10;
	localparam int SLOTS    = 1024;
	localparam int WORD_SEL = 6;

	// ------------------------------------------------------------------
	// Measurement enable bit positions
	// ------------------------------------------------------------------
	localparam int MEAS_READING_OVERFLOW     = 0;
	localparam int MEAS_LOW_LIMIT_ONE        = 1;
	localparam int MEAS_HIGH_LIMIT_ONE       = 2;
	localparam int MEAS_LOW_LIMIT_TWO        = 3;
	localparam int MEAS_HIGH_LIMIT_TWO       = 4;
	localparam int MEAS_READING_AVAILABLE    = 5;
	localparam int MEAS_BUFFER_AVAILABLE     = 7;
	localparam int MEAS_BUFFER_HALF_FULL     = 8;
	localparam int MEAS_BUFFER_FULL          = 9;
	localparam int MEAS_READING_UNDERFLOW    = 11;
	localparam int MEAS_DISTORTION_FREQ_OVF  = 12;
	localparam int MEAS_DISTORTION_FREQ_UNF  = 13;
	localparam int MEAS_SHAPING_FILTER_ERROR = 14;

	// ------------------------------------------------------------------
	// Questionable and operation enable bit positions
	// ------------------------------------------------------------------
	localparam int QUES_TEMPERATURE = 4;
	localparam int QUES_CALIBRATION = 8;
	localparam int QUES_CMD_WARNING = 14;
	localparam int OPER_MEASURING   = 4;
	localparam int OPER_TRIGGERING  = 5;
	localparam int OPER_IDLE        = 10;

	// Implemented bits of each set; bit 15 and unused bits read zero.
	localparam logic [15:0] MEAS_MASK = 16'h7bbf;
	localparam logic [15:0] QUES_MASK = 16'h4110;
	localparam logic [15:0] OPER_MASK = 16'h0430;

	// ------------------------------------------------------------------
	// Reset values and message codes
	// ------------------------------------------------------------------
	localparam logic [15:0] ENABLE_RST = 16'h0000;
	localparam logic [15:0] CODE_OVERFLOW = 16'h015e;
	localparam logic [15:0] CODE_NO_ERROR = 16'h0000;
	// Code window held in the message filter, codes -512 to +511.
	localparam logic signed [15:0] WIN_LO = 16'hfe00;
	localparam logic signed [15:0] WIN_HI = 16'h01ff;
	// Negative (error) codes admitted, positive (status) codes blocked.
	localparam logic [1023:0] MSG_EN_RST = {{512{1'b0}}, {512{1'b1}}};

	// ------------------------------------------------------------------
	// Commands, states and carriers
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_WR_MEAS_EN, OP_WR_QUES_EN, OP_WR_OPER_EN,
		OP_RD_MEAS_EN, OP_RD_QUES_EN, OP_RD_OPER_EN,
		OP_RD_MEAS_COND, OP_RD_QUES_COND, OP_RD_OPER_COND,
		OP_STAT_PRESET, OP_QUEUE_NEXT, OP_QUEUE_CLEAR,
		OP_ENAB_LIST_START, OP_ENAB_RANGE, OP_DIS_RANGE,
		OP_RD_ENAB_WORD, OP_RD_DIS_WORD,
		OP_WR_BEEP, OP_RD_BEEP, OP_WR_KEY_CLICK_ENABLE, OP_RD_KEY_CLICK_ENABLE
	} isr_op_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_EXEC, ST_SWEEP
	} isr_state_t;

	typedef struct packed {
		isr_op_t     op;
		logic [15:0] data;
		logic [15:0] data2;
	} isr_cmd_t;

	typedef struct packed {
		logic [15:0] meas;
		logic [15:0] ques;
		logic [15:0] oper;
	} isr_set_t;

endpackage : isr_pkg

/* rtl/isr_msg_mem.sv */
// Message store of the error queue with a registered read port.
`timescale 1ns/1ps
module isr_msg_mem (
	input  wire logic                        mclk_in,
	input  wire logic                        rst_b_in,
	input  wire logic                        we_in,
	input  wire logic [isr_pkg::QADDR_W-1:0] waddr_in,
	input  wire logic [isr_pkg::DATA_W-1:0]  wdata_in,
	input  wire logic [isr_pkg::QADDR_W-1:0] raddr_in,
	output logic      [isr_pkg::DATA_W-1:0]  rdata_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [(1<<isr_pkg::QADDR_W)-1:0][isr_pkg::DATA_W-1:0] mem;
		logic [isr_pkg::DATA_W-1:0]                             rdata;
	} isr_mem_regs_t;

	isr_mem_regs_t q_r;
	isr_mem_regs_t q_nxt;

	// Read data always shows the slot addressed one edge earlier.
	always_comb begin
		q_nxt = q_r;
		q_nxt.rdata = q_r.mem[raddr_in];
		if (we_in) begin
			q_nxt.mem[waddr_in] = wdata_in;
		end
	end

	// Register the whole state.
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign rdata_out = q_r.rdata;

endmodule : isr_msg_mem

/* rtl/isr_status.sv */
// Status reporting core: enable masks, condition mirrors, error queue.
//
// Behaviour
// - Measurement enable is 16 bits, listed event bits only, others zero.
// - Questionable enable holds bits 14, 8, 4; bit 15 reads zero.
// - A one in an enable bit passes its event, a zero masks it.
// - Operation enable holds idle bit 10, triggering bit 5, measuring 4.
// - Masked events never set the summary; enabled set events do.
// - Each set has a condition register mirroring live status.
// - Condition read returns the register as one binary weighted value.
// - Status preset zeroes the three enable masks, nothing else.
// - Error queue is first in first out; a read pops the oldest.
// - Queue holds ten; filling it puts code 350 in the last slot.
// - Queue empty after reset; reading it empty returns code 0.
// - Messages carry signed codes, negative standard, positive vendor.
// - Queue clear discards every held message.
// - After reset error codes pass, status codes are blocked.
// - Enable list first disables all codes then enables listed ones.
// - Disable list blocks listed codes; query returns disabled ones.
// - Beeper enable bit, one enables and zero disables, readable.
// - Key click bit set by command, read back, toggled by key sequence.
`timescale 1ns/1ps
module isr_status (
	input  wire logic                       mclk_in,
	input  wire logic                       rst_b_in,
	input  wire logic                       cmd_valid_in,
	input  wire isr_pkg::isr_cmd_t          cmd_in,
	input  wire isr_pkg::isr_set_t          event_in,
	input  wire isr_pkg::isr_set_t          cond_in,
	input  wire logic                       msg_valid_in,
	input  wire logic signed [15:0]         msg_code_in,
	input  wire logic                       key_shift_local_in,
	output logic                            busy_out,
	output logic                            rsp_valid_out,
	output logic [isr_pkg::DATA_W-1:0]      rsp_data_out,
	output logic                            meas_summary_out,
	output logic                            ques_summary_out,
	output logic                            oper_summary_out,
	output logic                            beeper_en_out,
	output logic                            key_click_enable_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		isr_pkg::isr_state_t          st;
		isr_pkg::isr_op_t             op;
		logic [15:0]                  arg;
		logic                         q_empty;
		logic [isr_pkg::SLOT_W-1:0]   cur;
		logic [isr_pkg::SLOT_W-1:0]   hi;
		logic                         set_val;
		logic [isr_pkg::SLOTS-1:0]    msg_en;
		isr_pkg::isr_set_t            en;
		isr_pkg::isr_set_t            sync1;
		isr_pkg::isr_set_t            cond;
		logic                         meas_sum;
		logic                         ques_sum;
		logic                         oper_sum;
		logic                         beep;
		logic                         key_click_enable;
		logic [isr_pkg::QADDR_W-1:0]  wr_ptr;
		logic [isr_pkg::QADDR_W-1:0]  rd_ptr;
		logic [isr_pkg::QADDR_W-1:0]  count;
		logic                         rsp_valid;
		logic [15:0]                  rsp_data;
		logic                         busy;
	} isr_regs_t;

	isr_regs_t                   q_r;
	isr_regs_t                   q_nxt;
	logic                        mem_we;
	logic [isr_pkg::QADDR_W-1:0] mem_waddr;
	logic [15:0]                 mem_wdata;
	logic [15:0]                 mem_rdata;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Filter slot of a code, clamped to the ends of the held window.
	function automatic logic [isr_pkg::SLOT_W-1:0] slot_of(
		input logic signed [15:0] code
	);
		logic signed [16:0] off;
		off = 17'({code[15], code}) - 17'({isr_pkg::WIN_LO[15],
			isr_pkg::WIN_LO});
		if (code < isr_pkg::WIN_LO) begin
			slot_of = '0;
		end else if (code > isr_pkg::WIN_HI) begin
			slot_of = '1;
		end else begin
			slot_of = off[isr_pkg::SLOT_W-1:0];
		end
	endfunction : slot_of

	// Ring pointer step that wraps after the last queue slot.
	function automatic logic [isr_pkg::QADDR_W-1:0] ptr_inc(
		input logic [isr_pkg::QADDR_W-1:0] p
	);
		if (p == 4'(isr_pkg::QDEPTH - 1)) begin
			ptr_inc = '0;
		end else begin
			ptr_inc = p + 4'h1;
		end
	endfunction : ptr_inc

	// ------------------------------------------------------------------
	// Message store
	// ------------------------------------------------------------------
	isr_msg_mem u_mem (
		.mclk_in   (mclk_in),
		.rst_b_in  (rst_b_in),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (q_r.rd_ptr),
		.rdata_out (mem_rdata)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// One process builds every next value; the command sequencer
	// only accepts a new command when idle, so the host must watch busy.
	always_comb begin
		logic signed [15:0] lo_c;
		logic signed [15:0] hi_c;
		logic               pop;
		logic               clr;
		logic               admit;
		logic [3:0]         cnt;
		logic [3:0]         rp;
		logic [3:0]         wp;
		q_nxt = q_r;
		cnt = q_r.count;
		rp = q_r.rd_ptr;
		wp = q_r.wr_ptr;
		lo_c = '0;
		hi_c = '0;
		pop = 1'b0;
		clr = 1'b0;
		admit = 1'b0;
		q_nxt.rsp_valid = 1'b0;
		mem_we = 1'b0;
		mem_waddr = q_r.wr_ptr;
		mem_wdata = msg_code_in;

		// Live status passes two flops; the second stage is the mirror.
		q_nxt.sync1 = cond_in;
		q_nxt.cond = q_r.sync1;

		// Summaries follow the events every cycle through the masks.
		q_nxt.meas_sum = |(event_in.meas & q_r.en.meas);
		q_nxt.ques_sum = |(event_in.ques & q_r.en.ques);
		q_nxt.oper_sum = |(event_in.oper & q_r.en.oper);

		// Front panel sequence flips the click; a command below wins.
		if (key_shift_local_in) begin
			q_nxt.key_click_enable = ~q_r.key_click_enable;
		end

		case (q_r.st)
			isr_pkg::ST_IDLE: begin
				if (cmd_valid_in) begin
					q_nxt.op = cmd_in.op;
					q_nxt.arg = cmd_in.data;
					q_nxt.q_empty = (q_r.count == '0);
					q_nxt.st = isr_pkg::ST_EXEC;
					if (cmd_in.op == isr_pkg::OP_ENAB_RANGE ||
						cmd_in.op == isr_pkg::OP_DIS_RANGE) begin
						// Ranges may be written high to low.
						if ($signed(cmd_in.data) <= $signed(cmd_in.data2))
						begin
							lo_c = cmd_in.data;
							hi_c = cmd_in.data2;
						end else begin
							lo_c = cmd_in.data2;
							hi_c = cmd_in.data;
						end
						q_nxt.cur = slot_of(lo_c);
						q_nxt.hi = slot_of(hi_c);
						q_nxt.set_val =
							(cmd_in.op == isr_pkg::OP_ENAB_RANGE);
						// A range wholly outside the window is dropped.
						if (hi_c >= isr_pkg::WIN_LO &&
							lo_c <= isr_pkg::WIN_HI) begin
							q_nxt.st = isr_pkg::ST_SWEEP;
						end else begin
							q_nxt.st = isr_pkg::ST_IDLE;
						end
					end
				end
			end
			isr_pkg::ST_EXEC: begin
				q_nxt.st = isr_pkg::ST_IDLE;
				case (q_r.op)
					isr_pkg::OP_WR_MEAS_EN: begin
						q_nxt.en.meas = q_r.arg & isr_pkg::MEAS_MASK;
					end
					isr_pkg::OP_WR_QUES_EN: begin
						q_nxt.en.ques = q_r.arg & isr_pkg::QUES_MASK;
					end
					isr_pkg::OP_WR_OPER_EN: begin
						q_nxt.en.oper = q_r.arg & isr_pkg::OPER_MASK;
					end
					isr_pkg::OP_RD_MEAS_EN: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = q_r.en.meas;
					end
					isr_pkg::OP_RD_QUES_EN: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = q_r.en.ques;
					end
					isr_pkg::OP_RD_OPER_EN: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = q_r.en.oper;
					end
					isr_pkg::OP_RD_MEAS_COND: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = q_r.cond.meas & isr_pkg::MEAS_MASK;
					end
					isr_pkg::OP_RD_QUES_COND: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = q_r.cond.ques & isr_pkg::QUES_MASK;
					end
					isr_pkg::OP_RD_OPER_COND: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = q_r.cond.oper & isr_pkg::OPER_MASK;
					end
					isr_pkg::OP_STAT_PRESET: begin
						q_nxt.en.meas = isr_pkg::ENABLE_RST;
						q_nxt.en.ques = isr_pkg::ENABLE_RST;
						q_nxt.en.oper = isr_pkg::ENABLE_RST;
					end
					isr_pkg::OP_QUEUE_NEXT: begin
						q_nxt.rsp_valid = 1'b1;
						if (q_r.q_empty) begin
							q_nxt.rsp_data = isr_pkg::CODE_NO_ERROR;
						end else begin
							q_nxt.rsp_data = mem_rdata;
							pop = 1'b1;
						end
					end
					isr_pkg::OP_QUEUE_CLEAR: begin
						clr = 1'b1;
					end
					isr_pkg::OP_ENAB_LIST_START: begin
						// Opening a list with no ranges blocks every code.
						q_nxt.msg_en = '0;
					end
					isr_pkg::OP_RD_ENAB_WORD: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data =
							q_r.msg_en[q_r.arg[isr_pkg::WORD_SEL-1:0]*16 +: 16];
					end
					isr_pkg::OP_RD_DIS_WORD: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data =
							~q_r.msg_en[q_r.arg[isr_pkg::WORD_SEL-1:0]*16 +: 16];
					end
					isr_pkg::OP_WR_BEEP: begin
						q_nxt.beep = q_r.arg[0];
					end
					isr_pkg::OP_RD_BEEP: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = {15'h0000, q_r.beep};
					end
					isr_pkg::OP_WR_KEY_CLICK_ENABLE: begin
						q_nxt.key_click_enable = q_r.arg[0];
					end
					isr_pkg::OP_RD_KEY_CLICK_ENABLE: begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data = {15'h0000, q_r.key_click_enable};
					end
					default: begin
						q_nxt.st = isr_pkg::ST_IDLE;
					end
				endcase
			end
			isr_pkg::ST_SWEEP: begin
				// One filter slot per cycle keeps the range logic small
				// at the price of up to 1024 busy cycles per range.
				q_nxt.msg_en[q_r.cur] = q_r.set_val;
				if (q_r.cur == q_r.hi) begin
					q_nxt.st = isr_pkg::ST_IDLE;
				end else begin
					q_nxt.cur = q_r.cur + 10'h001;
				end
			end
			default: begin
				q_nxt.st = isr_pkg::ST_IDLE;
			end
		endcase

		// Queue bookkeeping: clear, then pop, then push, so a message
		// arriving with a clear or a pop is still kept.
		if (clr) begin
			cnt = '0;
			rp = '0;
			wp = '0;
		end
		if (pop) begin
			rp = ptr_inc(rp);
			cnt = cnt - 4'h1;
		end
		// Codes beyond the window share the bit of its nearest end, so
		// an empty enable list blocks them as well.
		admit = q_r.msg_en[slot_of(msg_code_in)];
		if (msg_valid_in && admit && cnt < 4'(isr_pkg::QDEPTH)) begin
			mem_we = 1'b1;
			mem_waddr = wp;
			// The last free slot always takes the overflow marker.
			if (cnt == 4'(isr_pkg::QDEPTH - 1)) begin
				mem_wdata = isr_pkg::CODE_OVERFLOW;
			end
			wp = ptr_inc(wp);
			cnt = cnt + 4'h1;
		end
		q_nxt.count = cnt;
		q_nxt.rd_ptr = rp;
		q_nxt.wr_ptr = wp;

		q_nxt.busy = (q_nxt.st != isr_pkg::ST_IDLE);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Queue starts empty and the filter passes only error codes.
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			q_r <= '0;
			q_r.msg_en <= isr_pkg::MSG_EN_RST;
			q_r.en <= {3{isr_pkg::ENABLE_RST}};
		end else begin
			q_r <= q_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign busy_out             = q_r.busy;
	assign rsp_valid_out        = q_r.rsp_valid;
	assign rsp_data_out         = q_r.rsp_data;
	assign meas_summary_out     = q_r.meas_sum;
	assign ques_summary_out     = q_r.ques_sum;
	assign oper_summary_out     = q_r.oper_sum;
	assign beeper_en_out        = q_r.beep;
	assign key_click_enable_out = q_r.key_click_enable;

endmodule : isr_status

/* sim/isr_checker.sv */
// Port-level checks of the status reporting core.
`timescale 1ns/1ps
module isr_checker (
	input wire logic              mclk_in,
	input wire logic              rst_b_in,
	input wire logic              cmd_valid_in,
	input wire isr_pkg::isr_cmd_t cmd_in,
	input wire isr_pkg::isr_set_t event_in,
	input wire isr_pkg::isr_set_t cond_in,
	input wire logic              msg_valid_in,
	input wire logic signed [15:0] msg_code_in,
	input wire logic              key_shift_local_in,
	input wire logic              busy_out,
	input wire logic              rsp_valid_out,
	input wire logic [15:0]       rsp_data_out,
	input wire logic              meas_summary_out,
	input wire logic              ques_summary_out,
	input wire logic              oper_summary_out,
	input wire logic              beeper_en_out,
	input wire logic              key_click_enable_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// A command only counts when the core is idle to take it.
	logic taken;
	assign taken = cmd_valid_in && !busy_out;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	// Summaries never rise from events that have no implemented enable.
	meas_sum_mask_a: assert property (
		(event_in.meas & isr_pkg::MEAS_MASK) == 16'h0 |=>
		!meas_summary_out) else $error("meas summary");
	ques_sum_mask_a: assert property (
		(event_in.ques & isr_pkg::QUES_MASK) == 16'h0 |=>
		!ques_summary_out) else $error("ques summary");
	oper_sum_mask_a: assert property (
		(event_in.oper & isr_pkg::OPER_MASK) == 16'h0 |=>
		!oper_summary_out) else $error("oper summary");
	query_answer_a: assert property (
		taken && cmd_in.op inside {isr_pkg::OP_RD_MEAS_COND,
		isr_pkg::OP_QUEUE_NEXT} |-> ##2 rsp_valid_out)
		else $error("no answer");
	answer_cause_a: assert property (
		rsp_valid_out |-> $past(taken, 2))
		else $error("answer without command");
	meas_cond_bits_a: assert property (
		taken && cmd_in.op == isr_pkg::OP_RD_MEAS_COND |-> ##2
		(rsp_data_out & ~isr_pkg::MEAS_MASK) == 16'h0)
		else $error("meas bits");
	ques_top_bit_a: assert property (
		taken && cmd_in.op inside {isr_pkg::OP_RD_QUES_EN,
		isr_pkg::OP_RD_QUES_COND} |-> ##2 !rsp_data_out[15])
		else $error("ques bit 15");
	click_toggle_a: assert property (
		key_shift_local_in && !cmd_valid_in && !busy_out |=>
		key_click_enable_out != $past(key_click_enable_out))
		else $error("click toggle");
	beep_hold_a: assert property (
		!cmd_valid_in && !busy_out |=> $stable(beeper_en_out))
		else $error("beeper moved");
	preset_beep_a: assert property (
		taken && cmd_in.op == isr_pkg::OP_STAT_PRESET |=> ##1
		$stable(beeper_en_out)) else $error("preset moved beeper");
	// A beeper write shows on the pin two edges after it is taken.
	beep_write_a: assert property (
		taken && cmd_in.op == isr_pkg::OP_WR_BEEP |-> ##2
		beeper_en_out == $past(cmd_in.data[0], 2))
		else $error("beeper write");
	// A queue read holds the port busy for exactly one cycle.
	queue_busy_a: assert property (
		taken && cmd_in.op == isr_pkg::OP_QUEUE_NEXT |=> busy_out
		##1 !busy_out) else $error("queue read busy");

	// Main scenarios reached.
	cover property (taken && cmd_in.op == isr_pkg::OP_STAT_PRESET);
	cover property (taken && cmd_in.op == isr_pkg::OP_ENAB_RANGE);
	cover property (meas_summary_out && ques_summary_out);
endmodule : isr_checker

bind isr_status isr_checker chk_i (
	.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
	.cmd_in(cmd_in), .event_in(event_in), .cond_in(cond_in),
	.msg_valid_in(msg_valid_in), .msg_code_in(msg_code_in),
	.key_shift_local_in(key_shift_local_in), .busy_out(busy_out),
	.rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
	.meas_summary_out(meas_summary_out),
	.ques_summary_out(ques_summary_out),
	.oper_summary_out(oper_summary_out), .beeper_en_out(beeper_en_out),
	.key_click_enable_out(key_click_enable_out));

/* sim/isr_host.sv */
// Remote host model issuing commands, messages and key presses.
`timescale 1ns/1ps
module isr_host (
	input  wire logic         mclk_in,
	input  wire logic         busy_in,
	input  wire logic         rsp_valid_in,
	input  wire logic [15:0]  rsp_data_in,
	output isr_pkg::isr_cmd_t cmd_out,
	output logic              cmd_valid_out,
	output logic              msg_valid_out,
	output logic signed [15:0] msg_code_out,
	output logic              key_out
);
	logic [15:0] rsp;
	logic        got;

	initial begin
		cmd_out = '0;
		cmd_valid_out = 1'b0;
		msg_valid_out = 1'b0;
		msg_code_out = 16'h0000;
		key_out = 1'b0;
	end

	// Offers one command for one cycle once idle, then takes the answer.
	// Codes go out as single values or inclusive ranges.
	task automatic cmd(input isr_pkg::isr_op_t op, input logic [15:0] d,
		input logic [15:0] d2);
		int n;
		for (n = 0; n < 2000 && busy_in !== 1'b0; n++) begin
			@(posedge mclk_in);
			#1;
		end
		@(posedge mclk_in);
		cmd_valid_out <= 1'b1;
		cmd_out <= '{op, d, d2};
		@(posedge mclk_in);
		cmd_valid_out <= 1'b0;
		@(posedge mclk_in);
		#1 got = rsp_valid_in;
		rsp = rsp_data_in;
		for (n = 0; n < 2000 && busy_in !== 1'b0; n++) begin
			@(posedge mclk_in);
			#1;
		end
	endtask : cmd

	// The code line is inverted after use so a stale value never matches.
	task automatic push(input logic signed [15:0] c);
		@(posedge mclk_in);
		msg_valid_out <= 1'b1;
		msg_code_out <= c;
		@(posedge mclk_in);
		msg_valid_out <= 1'b0;
		msg_code_out <= ~c;
	endtask : push

	task automatic key();
		@(posedge mclk_in);
		key_out <= 1'b1;
		@(posedge mclk_in);
		key_out <= 1'b0;
	endtask : key
endmodule : isr_host

/* sim/tb_top.sv */
// Self-checking testbench of the status reporting core.
`timescale 1ns/1ps
module tb_top;
	logic              mclk_in;
	logic              rst_b_in;
	isr_pkg::isr_set_t ev;
	isr_pkg::isr_set_t cond;
	isr_pkg::isr_cmd_t cmd;
	logic              cmd_valid, msg_valid, key, busy, rv;
	logic              ms, qs, os, beep, click;
	logic signed [15:0] code;
	logic [15:0]       rd;
	int                failures, tests_run, i;

	isr_status DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .event_in(ev),
		.cond_in(cond), .msg_valid_in(msg_valid), .msg_code_in(code),
		.key_shift_local_in(key), .busy_out(busy), .rsp_valid_out(rv),
		.rsp_data_out(rd), .meas_summary_out(ms), .ques_summary_out(qs),
		.oper_summary_out(os), .beeper_en_out(beep),
		.key_click_enable_out(click));
	isr_host host (.mclk_in(mclk_in), .busy_in(busy), .rsp_valid_in(rv),
		.rsp_data_in(rd), .cmd_out(cmd), .cmd_valid_out(cmd_valid),
		.msg_valid_out(msg_valid), .msg_code_out(code), .key_out(key));

	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	// ---------------------------------------------------------------
	// Comparison helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// A query must answer with the valid pulse as well as the value.
	task automatic q(input string nm, input isr_pkg::isr_op_t op,
		input logic [15:0] d, input logic [15:0] e);
		host.cmd(op, d, d);
		chk({nm, " valid"}, 16'h0001, {15'h0, host.got});
		chk(nm, e, host.rsp);
	endtask : q

	// Events are applied at an edge; summaries follow one edge later.
	task automatic sev(input isr_pkg::isr_set_t v, input logic [2:0] e);
		@(posedge mclk_in);
		ev <= v;
		repeat (2) @(posedge mclk_in);
		#1 chk("summary", {13'h0, e}, {13'h0, ms, qs, os});
	endtask : sev

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// Sweeps are the longest commands; the span leaves wide margin.
	initial begin
		#100us;
		failures++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		failures = 0;
		tests_run = 0;
		ev = '0;
		cond = '0;
		rst_b_in = 1'b0;
		repeat (4) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		q("meas_en rst", isr_pkg::OP_RD_MEAS_EN, 0, 16'h0000);
		q("queue empty", isr_pkg::OP_QUEUE_NEXT, 0, 16'h0000);
		$display("test reset done");

		host.cmd(isr_pkg::OP_WR_MEAS_EN, 16'hffff, 0);
		host.cmd(isr_pkg::OP_WR_QUES_EN, 16'hffff, 0);
		host.cmd(isr_pkg::OP_WR_OPER_EN, 16'hffff, 0);
		q("meas_en", isr_pkg::OP_RD_MEAS_EN, 0, 16'h7bbf);
		q("ques_en", isr_pkg::OP_RD_QUES_EN, 0, 16'h4110);
		q("oper_en", isr_pkg::OP_RD_OPER_EN, 0, 16'h0430);
		host.cmd(isr_pkg::OP_WR_BEEP, 16'h0001, 0);
		host.cmd(isr_pkg::OP_STAT_PRESET, 0, 0);
		q("meas_en pre", isr_pkg::OP_RD_MEAS_EN, 0, 16'h0000);
		q("ques_en pre", isr_pkg::OP_RD_QUES_EN, 0, 16'h0000);
		q("oper_en pre", isr_pkg::OP_RD_OPER_EN, 0, 16'h0000);
		q("beep kept", isr_pkg::OP_RD_BEEP, 0, 16'h0001);
		chk("beep pin", 16'h0001, {15'h0, beep});
		host.cmd(isr_pkg::OP_WR_BEEP, 16'h0000, 0);
		q("beep off", isr_pkg::OP_RD_BEEP, 0, 16'h0000);
		host.key();
		q("click key", isr_pkg::OP_RD_KEY_CLICK_ENABLE, 0, 16'h0001);
		host.cmd(isr_pkg::OP_WR_KEY_CLICK_ENABLE, 16'h0000, 0);
		q("click off", isr_pkg::OP_RD_KEY_CLICK_ENABLE, 0, 16'h0000);
		$display("test enables done");

		host.cmd(isr_pkg::OP_WR_MEAS_EN, 16'h0200, 0);
		host.cmd(isr_pkg::OP_WR_QUES_EN, 16'h0100, 0);
		host.cmd(isr_pkg::OP_WR_OPER_EN, 16'h0410, 0);
		sev('{16'h0020, 16'h0010, 16'h0020}, 3'b000);
		sev('{16'h0200, 16'h0100, 16'h0010}, 3'b111);
		sev('{16'h0200, 16'h0000, 16'h0400}, 3'b101);
		@(posedge mclk_in);
		cond <= '{16'hffff, 16'hffff, 16'hffff};
		repeat (3) @(posedge mclk_in);
		q("meas cond", isr_pkg::OP_RD_MEAS_COND, 0, 16'h7bbf);
		q("ques cond", isr_pkg::OP_RD_QUES_COND, 0, 16'h4110);
		q("oper cond", isr_pkg::OP_RD_OPER_COND, 0, 16'h0430);
		@(posedge mclk_in);
		cond <= '{16'h0200, 16'h0000, 16'h0000};
		repeat (3) @(posedge mclk_in);
		q("cond full", isr_pkg::OP_RD_MEAS_COND, 0, 16'h0200);
		$display("test summary done");

		host.push(-16'sd110);
		host.push(16'sd5);
		host.push(-16'sd222);
		q("q first", isr_pkg::OP_QUEUE_NEXT, 0, 16'hff92);
		q("q second", isr_pkg::OP_QUEUE_NEXT, 0, 16'hff22);
		q("q drained", isr_pkg::OP_QUEUE_NEXT, 0, 16'h0000);
		for (i = 1; i <= 12; i++)
			host.push(16'(-i));
		for (i = 1; i <= 9; i++)
			q("q fill", isr_pkg::OP_QUEUE_NEXT, 0, 16'(-i));
		q("q ovf", isr_pkg::OP_QUEUE_NEXT, 0, 16'h015e);
		q("q after", isr_pkg::OP_QUEUE_NEXT, 0, 16'h0000);
		host.push(-16'sd1);
		host.push(-16'sd2);
		host.cmd(isr_pkg::OP_QUEUE_CLEAR, 0, 0);
		q("q clear", isr_pkg::OP_QUEUE_NEXT, 0, 16'h0000);
		$display("test queue done");

		host.cmd(isr_pkg::OP_ENAB_LIST_START, 0, 0);
		host.cmd(isr_pkg::OP_ENAB_RANGE, 16'hff9c, 16'hff88);
		host.cmd(isr_pkg::OP_DIS_RANGE, 16'hff92, 16'hff92);
		q("enab word", isr_pkg::OP_RD_ENAB_WORD, 16'h0019, 16'h1ffb);
		q("dis word", isr_pkg::OP_RD_DIS_WORD, 16'h0019, 16'he004);
		host.push(-16'sd110);
		host.push(-16'sd111);
		host.push(-16'sd130);
		q("q listed", isr_pkg::OP_QUEUE_NEXT, 0, 16'hff91);
		q("q unlisted", isr_pkg::OP_QUEUE_NEXT, 0, 16'h0000);
		host.cmd(isr_pkg::OP_ENAB_LIST_START, 0, 0);
		host.push(-16'sd111);
		host.push(-16'sd600);
		q("q none", isr_pkg::OP_QUEUE_NEXT, 0, 16'h0000);
		$display("test filter done");
		stop_test();
	end
endmodule : tb_top
